// ===== rtl/azs_pkg.sv
package azs_pkg;

    // ========================================================================
    // Widths, start values and trial count.
    localparam int          CODE_W        = 8;
    localparam logic [7:0]  PTR_START     = 8'h80;
    localparam logic [7:0]  CODE_START    = 8'h7F;
    localparam int          TRIALS        = 8;

    // ========================================================================
    // Interrupt status bit positions.
    localparam int          EV_DONE       = 0;
    localparam int          EV_TRIAL      = 1;
    localparam int          EV_SAMPLE     = 2;
    localparam int          EV_W          = 3;

    // ========================================================================
    // Register byte offsets, one aligned word each.
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STAT      = 8'h04;
    localparam logic [7:0]  OFS_CODE      = 8'h08;
    localparam logic [7:0]  OFS_DATA      = 8'h0C;
    localparam logic [7:0]  OFS_IRQS      = 8'h10;
    localparam logic [7:0]  OFS_IRQM      = 8'h14;

    // ========================================================================
    // Control register bits.
    localparam int          CTRL_ZERO     = 0;
    localparam int          CTRL_CONV     = 1;

    // ========================================================================
    // Bus answers and start pulse timing.
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam int          CLK_MHZ       = 25;
    localparam int          START_NS      = 200;
    localparam int          START_CYC     = (START_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        AZS_IDLE, AZS_START, AZS_WAIT, AZS_JUDGE, AZS_READY
    } azs_state_e;

    typedef struct packed {
        logic        shortSw;
        logic        signalSw;
        logic        startN;
        logic [7:0]  code;
    } azs_pins_s;

    typedef struct packed {
        logic        busy;
        logic        zeroed;
        logic        resultReady;
    } azs_status_s;

endpackage

// ===== rtl/azs_bit_sync.sv
`timescale 1ns/1ps
`default_nettype none

module azs_bit_sync #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    import azs_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } azs_sync_s;

    azs_sync_s state_r;
    azs_sync_s state_nxt;

    initial begin
        if (WIDTH < 1) begin
            $error("azs_bit_sync needs at least one bit.");
        end
    end

    // ========================================================================
    // Two flops; only the second stage is visible outside.
    always_comb begin
        state_nxt      = state_r;
        state_nxt.meta = asyncIn;
        state_nxt.sync = state_r.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '{meta: '1, sync: '1};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign syncOut = state_r.sync;

endmodule
`default_nettype wire

// ===== rtl/azs_sequencer.sv
// Contract
// R1 - Shorting switch closed during zeroing, then opened and signal switch closed.
// R2 - Two separate switch controls, driven alternately, never both on.
// R3 - Converter gives all-zero result when its minus input exceeds plus.
// R4 - Invert the converter result read and outputs through inverting buffers.
// R5 - Zero result clears the trial bit before the next conversion.
// R6 - Nonzero result sets the trial bit before the next conversion.
// R7 - Exactly eight trials, then end zeroing and hold final code.
// R8 - Eight-bit correction code always presented on its own output port.
// R9 - Result input, code, switch and configuration ports kept distinct.
// R10 - Result port is input; code and switch ports are outputs.
// R11 - Completion interrupt leads into the result-read step.
// R12 - Trial pointer starts at the top bit, value 80 hex.
// R13 - Pointer shifts right after each trial; empty pointer ends zeroing.
// R14 - Start a conversion after each code update, wait for completion. The code starts none after the eighth trial's update; zeroing ends there.
`timescale 1ns/1ps
`default_nettype none

module azs_sequencer (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output var  logic               s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output var  logic               s_axi_wready,
    output var  logic [1:0]         s_axi_bresp,
    output var  logic               s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output var  logic               s_axi_arready,
    output var  logic [31:0]        s_axi_rdata,
    output var  logic [1:0]         s_axi_rresp,
    output var  logic               s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic [7:0]         adcDataN,
    input  wire logic               conversion_done_irq_n,
    output var  azs_pkg::azs_pins_s pinsN,
    output var  logic               irq
);
    import azs_pkg::*;

    typedef struct packed {
        azs_state_e              fsm;
        logic [7:0]              code;
        logic [7:0]              ptr;
        logic [3:0]              trials;
        logic [7:0]              result;
        logic [7:0]              startCnt;
        logic                    zeroing;
        logic                    zeroed;
        logic                    resultReady;
        logic                    convReq;
        logic [EV_W-1:0]         irqStat;
        logic [EV_W-1:0]         irqMask;
        logic                    awHeld;
        logic                    wHeld;
        logic [7:0]              awAddr;
        logic [31:0]             wData;
        logic [3:0]              wStrb;
        logic                    bValid;
        logic [1:0]              bResp;
        logic                    rValid;
        logic [31:0]             rData;
        logic [1:0]              rResp;
    } azs_state_s;

    azs_state_s state_r;
    azs_state_s state_nxt;
    logic [7:0] dataSyncN;
    logic       doneSyncN;
    logic [7:0] trueData;
    logic [EV_W-1:0] events;
    logic       wrFire;
    logic       wrZero;
    logic       wrConv;

    initial begin
        if (START_CYC < 1) begin
            $error("Start pulse must last at least one cycle.");
        end
        if (TRIALS != CODE_W) begin
            $error("One trial per code bit is needed.");
        end
    end

    // ========================================================================
    // Pin synchronisers.
    azs_bit_sync #(.WIDTH(9)) uSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn ({conversion_done_irq_n, adcDataN}),
        .syncOut ({doneSyncN, dataSyncN})
    );

    // The result port arrives through inverting buffers.
    assign trueData = ~dataSyncN; // R4

    // ========================================================================
    // Register bus and sequencer.
    always_comb begin
        state_nxt = state_r;
        events    = '0;
        wrFire    = 1'b0;
        wrZero    = 1'b0;
        wrConv    = 1'b0;

        if (s_axi_awvalid && !state_r.awHeld) begin
            state_nxt.awHeld = 1'b1;
            state_nxt.awAddr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !state_r.wHeld) begin
            state_nxt.wHeld = 1'b1;
            state_nxt.wData = s_axi_wdata;
            state_nxt.wStrb = s_axi_wstrb;
        end
        if (state_r.bValid && s_axi_bready) begin
            state_nxt.bValid = 1'b0;
        end
        if (state_r.awHeld && state_r.wHeld && !state_r.bValid) begin
            wrFire           = 1'b1;
            state_nxt.awHeld = 1'b0;
            state_nxt.wHeld  = 1'b0;
            state_nxt.bValid = 1'b1;
            state_nxt.bResp  = RESP_OKAY;
            unique case (state_r.awAddr)
                OFS_CTRL: begin
                    wrZero = state_r.wStrb[0] && state_r.wData[CTRL_ZERO];
                    wrConv = state_r.wStrb[0] && state_r.wData[CTRL_CONV];
                end
                OFS_IRQM: begin
                    if (state_r.wStrb[0]) begin
                        state_nxt.irqMask = state_r.wData[EV_W-1:0];
                    end
                end
                OFS_IRQS, OFS_STAT, OFS_CODE, OFS_DATA: begin
                end
                default: state_nxt.bResp = RESP_SLVERR;
            endcase
        end

        if (state_r.rValid && s_axi_rready) begin
            state_nxt.rValid = 1'b0;
        end
        if (s_axi_arvalid && !state_r.rValid) begin
            state_nxt.rValid = 1'b1;
            state_nxt.rResp  = RESP_OKAY;
            state_nxt.rData  = '0;
            unique case (s_axi_araddr[7:0])
                OFS_CTRL: state_nxt.rData = '0;
                OFS_STAT: state_nxt.rData[2:0] = {state_r.resultReady,
                                                  state_r.zeroed,
                                                  state_r.zeroing};
                OFS_CODE: state_nxt.rData[7:0] = state_r.code;
                OFS_DATA: state_nxt.rData[7:0] = state_r.result;
                OFS_IRQS: state_nxt.rData[EV_W-1:0] = state_r.irqStat;
                OFS_IRQM: state_nxt.rData[EV_W-1:0] = state_r.irqMask;
                default:  state_nxt.rResp = RESP_SLVERR;
            endcase
            if (s_axi_araddr[7:0] == OFS_DATA) begin
                state_nxt.resultReady = 1'b0;
            end
        end

        if (wrConv && !state_r.zeroing) begin
            state_nxt.convReq = 1'b1;
        end

        unique case (state_r.fsm)
            AZS_IDLE: begin
                if (wrZero) begin
                    state_nxt.zeroing  = 1'b1; // R1
                    state_nxt.zeroed   = 1'b0;
                    state_nxt.ptr      = PTR_START; // R12
                    state_nxt.code     = CODE_START;
                    state_nxt.trials   = '0;
                    state_nxt.startCnt = 8'(START_CYC);
                    state_nxt.fsm      = AZS_START;
                end else if (state_r.convReq) begin
                    state_nxt.convReq  = 1'b0;
                    state_nxt.startCnt = 8'(START_CYC);
                    state_nxt.fsm      = AZS_START;
                end
            end
            AZS_START: begin
                state_nxt.startCnt = state_r.startCnt - 8'h01;
                if (state_r.startCnt == 8'h01) begin
                    state_nxt.fsm = AZS_WAIT;
                end
            end
            AZS_WAIT: begin
                if (!doneSyncN) begin
                    state_nxt.result = trueData; // R11
                    state_nxt.fsm    = AZS_JUDGE;
                end
            end
            AZS_JUDGE: begin
                if (!state_r.zeroing) begin
                    state_nxt.resultReady = 1'b1;
                    events[EV_SAMPLE]     = 1'b1;
                    state_nxt.fsm         = AZS_IDLE;
                end else begin
                    // A converter reports zero for any negative input.
                    if (state_r.result == 8'h00) begin // R3
                        state_nxt.code = state_r.code & ~state_r.ptr; // R5
                    end else begin
                        state_nxt.code = state_r.code | state_r.ptr; // R6
                    end
                    state_nxt.ptr    = state_r.ptr >> 1; // R13
                    state_nxt.trials = state_r.trials + 4'h1;
                    events[EV_TRIAL] = 1'b1;
                    if (state_r.ptr == 8'h01) begin // R7
                        state_nxt.zeroing = 1'b0;
                        state_nxt.zeroed  = 1'b1;
                        events[EV_DONE]   = 1'b1;
                        state_nxt.fsm     = AZS_IDLE;
                    end else begin
                        state_nxt.startCnt = 8'(START_CYC); // R14
                        state_nxt.fsm      = AZS_START;
                    end
                end
            end
            AZS_READY: state_nxt.fsm = AZS_IDLE;
        endcase

        // Set wins over a write-one clear in the same cycle.
        state_nxt.irqStat = state_r.irqStat;
        if (wrFire && state_r.awAddr == OFS_IRQS && state_r.wStrb[0]) begin
            state_nxt.irqStat = state_r.irqStat & ~state_r.wData[EV_W-1:0];
        end
        state_nxt.irqStat = state_nxt.irqStat | events;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r        <= '0;
            state_r.fsm    <= AZS_IDLE;
            state_r.code   <= CODE_START;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ========================================================================
    // Outputs; every pin is inverted by the external buffers.
    assign s_axi_awready = !state_r.awHeld;
    assign s_axi_wready  = !state_r.wHeld;
    assign s_axi_bvalid  = state_r.bValid;
    assign s_axi_bresp   = state_r.bResp;
    assign s_axi_arready = !state_r.rValid;
    assign s_axi_rvalid  = state_r.rValid;
    assign s_axi_rdata   = state_r.rData;
    assign s_axi_rresp   = state_r.rResp;
    assign irq           = |(state_r.irqStat & state_r.irqMask);

    // Separate pins for each switch, code and start keep the ports apart.
    assign pinsN = '{
        shortSw:  ~state_r.zeroing,            // R1 R2 R4 R9 R10
        signalSw: state_r.zeroing,             // R2
        startN:   ~(state_r.fsm == AZS_START), // R14
        code:     ~state_r.code                // R8
    };

    // ========================================================================
    // Checks.
    switch_alt_a: assert property (@(posedge clk) disable iff (rst) // R2
        pinsN.shortSw != pinsN.signalSw)
        else $error("Both switches in the same state.");
    short_zero_a: assert property (@(posedge clk) disable iff (rst) // R1
        state_r.zeroing |-> !pinsN.shortSw)
        else $error("Short switch open while zeroing.");
    ptr_start_a: assert property (@(posedge clk) disable iff (rst) // R12
        (state_r.fsm == AZS_IDLE && wrZero) |=> state_r.ptr == 8'h80)
        else $error("Pointer did not start at top bit.");
    ptr_shift_a: assert property (@(posedge clk) disable iff (rst) // R13
        (state_r.fsm == AZS_JUDGE && state_r.zeroing)
        |=> state_r.ptr == ($past(state_r.ptr) >> 1))
        else $error("Pointer did not shift.");
    clear_bit_a: assert property (@(posedge clk) disable iff (rst) // R5
        (state_r.fsm == AZS_JUDGE && state_r.zeroing
         && state_r.result == 8'h00)
        |=> (state_r.code & $past(state_r.ptr)) == 8'h00)
        else $error("Trial bit not cleared.");
    set_bit_a: assert property (@(posedge clk) disable iff (rst) // R6
        (state_r.fsm == AZS_JUDGE && state_r.zeroing
         && state_r.result != 8'h00)
        |=> (state_r.code & $past(state_r.ptr)) != 8'h00)
        else $error("Trial bit not set.");
    eight_trials_a: assert property (@(posedge clk) disable iff (rst) // R7
        $rose(state_r.zeroed) |-> state_r.trials == 4'h8)
        else $error("Zeroing did not take eight trials.");
    trial_cap_a: assert property (@(posedge clk) disable iff (rst) // R7
        state_r.zeroing |-> state_r.trials < 4'h8)
        else $error("More than eight trials.");
    code_out_a: assert property (@(posedge clk) disable iff (rst) // R8
        !(state_r.fsm == AZS_JUDGE || (state_r.fsm == AZS_IDLE && wrZero))
        |=> $stable(pinsN.code))
        else $error("Code pins changed outside a trial.");
    zero_end_a: assert property (@(posedge clk) disable iff (rst) // R1 R7
        (state_r.fsm == AZS_JUDGE && state_r.zeroing && state_r.ptr == 8'h01)
        |=> !state_r.zeroing && !pinsN.signalSw && state_r.fsm == AZS_IDLE)
        else $error("Zeroing did not end after the last trial.");
    start_wait_a: assert property (@(posedge clk) disable iff (rst) // R14
        (state_r.fsm == AZS_JUDGE && state_r.zeroing && state_r.ptr != 8'h01)
        |=> !pinsN.startN [*5])
        else $error("No start after code update.");
    start_len_a: assert property (@(posedge clk) disable iff (rst) // R14
        $fell(pinsN.startN) |-> !pinsN.startN [*5] ##1 pinsN.startN)
        else $error("Start pulse length wrong.");
    wait_done_a: assert property (@(posedge clk) disable iff (rst) // R14
        (state_r.fsm == AZS_WAIT && doneSyncN) |=> state_r.fsm == AZS_WAIT)
        else $error("Trial judged before completion.");
    read_inv_a: assert property (@(posedge clk) disable iff (rst) // R4 R11
        (state_r.fsm == AZS_WAIT && !doneSyncN)
        |=> state_r.result == ~$past(dataSyncN))
        else $error("Result not inverted on read.");
    sample_irq_a: assert property (@(posedge clk) disable iff (rst) // R11
        (state_r.fsm == AZS_JUDGE && !state_r.zeroing)
        |=> state_r.resultReady && state_r.irqStat[EV_SAMPLE])
        else $error("Result not flagged after conversion.");
    resp_hold_a: assert property (@(posedge clk) disable iff (rst)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("Write response withdrawn early.");
    rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
        (s_axi_rvalid && !s_axi_rready)
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data withdrawn early.");

    // ========================================================================
    // Cover points.
    zero_run_c: cover property (@(posedge clk) disable iff (rst)
        $rose(state_r.zeroed));
    single_conv_c: cover property (@(posedge clk) disable iff (rst)
        $rose(state_r.resultReady));
    irq_raise_c: cover property (@(posedge clk) disable iff (rst)
        $rose(irq));
    start_pulse_c: cover property (@(posedge clk) disable iff (rst)
        $fell(pinsN.startN));
    bus_error_c: cover property (@(posedge clk) disable iff (rst)
        s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule
`default_nettype wire

// ===== verif/azs_adc_model.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Converter and preamp switch network, seen through inverting buffers.
module azs_adc_model (
    input  wire azs_pkg::azs_pins_s pinsN,
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [7:0]         offset,
    input  wire logic [7:0]         sigVal,
    input  wire logic [7:0]         delay,
    output var  logic [7:0]         adcDataN,
    output var  logic               conversion_done_irq_n,
    output var  logic [7:0]         starts
);
    import azs_pkg::*;
    logic       startPrev;
    logic       busy;
    logic [7:0] cnt;
    logic [7:0] res;

    always @(posedge clk) begin
        startPrev <= pinsN.startN;
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            res <= 8'hA5;
            starts <= 8'h00;
            conversion_done_irq_n <= 1'b1;
        end else if (startPrev && !pinsN.startN) begin
            // A new start withdraws the previous completion flag.
            conversion_done_irq_n <= 1'b1;
            busy <= 1'b1;
            cnt <= 8'h00;
            starts <= starts + 8'h01;
        end else if (busy && pinsN.startN) begin
            if (cnt >= delay) begin
                busy <= 1'b0;
                conversion_done_irq_n <= 1'b0;
                if (!pinsN.shortSw) begin
                    // Shorted input: preamp offset against the code.
                    res <= (offset > ~pinsN.code) ? offset - ~pinsN.code
                                                  : 8'h00;
                end else begin
                    res <= sigVal;
                end
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    // Outside a valid result the lines show the inverse, so a read taken
    // at the wrong moment cannot match by luck.
    assign adcDataN = conversion_done_irq_n ? res : ~res;
endmodule
`default_nettype wire

// ===== verif/adc_preamp_auto_zero_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module adc_preamp_auto_zero_sequencer_tb;
    import azs_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic        irq, doneN;
    logic [1:0]  bresp, rresp;
    logic [7:0]  dataN, starts, offset = 0, sigVal = 0, delay = 0;
    azs_pins_s   pinsN;
    logic [34:0] expQ[$];
    int          n_mismatch = 0, total_checks = 0;

    always #20 clk = ~clk;

    azs_sequencer uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .adcDataN(dataN),
        .conversion_done_irq_n(doneN), .pinsN(pinsN), .irq(irq));
    azs_adc_model adc (.pinsN(pinsN), .clk(clk), .rst(rst),
        .offset(offset), .sigVal(sigVal), .delay(delay), .adcDataN(dataN),
        .conversion_done_irq_n(doneN), .starts(starts));

    // =================================================================
    // Checking and closing.
    task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t ns: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("Checks made %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic give_up;
        n_mismatch++;
        $display("Wait ran out at %0t ns", $time);
        print_verdict();
    endtask

    task automatic take(input logic [34:0] seen);
        logic [34:0] e;
        if (expQ.size() == 0) begin
            give_up();
        end else begin
            e = expQ.pop_front();
            // An error answer carries no defined data.
            if (e[33:32] == RESP_SLVERR) begin
                seen[31:0] = 32'h0;
            end
            chk(seen, e);
        end
    endtask

    always @(posedge clk) begin
        if (bvalid && bready) begin
            take({1'b0, bresp, 32'h0});
        end
        if (rvalid && rready) begin
            take({1'b1, rresp, rdata});
        end
        if (!rst) begin
            chk({34'h0, pinsN.signalSw}, {34'h0, ~pinsN.shortSw});
        end
    end

    // =================================================================
    // Bus master.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rsp);
        logic hA, hW, hB;
        int   n;
        expQ.push_back({1'b0, rsp, 32'h0});
        @(posedge clk);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hB = 1'b0;
        for (n = 0; n < 100 && !hB; n++) begin
            @(negedge clk);
            hA = awvalid && awready;
            hW = wvalid && wready;
            hB = bvalid && bready;
            @(posedge clk);
            if (hA) awvalid <= 1'b0;
            if (hW) wvalid <= 1'b0;
            if (hB) bready <= 1'b0;
        end
        if (!hB) give_up();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] rsp);
        logic hA, hR;
        int   n;
        expQ.push_back({1'b1, rsp, d});
        @(posedge clk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        hR = 1'b0;
        for (n = 0; n < 100 && !hR; n++) begin
            @(negedge clk);
            hA = arvalid && arready;
            hR = rvalid && rready;
            @(posedge clk);
            if (hA) arvalid <= 1'b0;
            if (hR) rready <= 1'b0;
        end
        if (!hR) give_up();
    endtask

    task automatic wait_until(input logic onIrq);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(negedge clk);
            if (onIrq ? irq === 1'b1 : pinsN.shortSw === 1'b1) return;
        end
        give_up();
    endtask

    // =================================================================
    // Scenarios.
    initial begin
        logic [7:0] offs [3];
        logic [7:0] c;
        logic [7:0] p;
        logic [7:0] s0;
        int         i;
        void'($urandom(32'h21f2));
        offs[0] = 8'h00;
        offs[1] = 8'hFF;
        offs[2] = 8'($urandom_range(254, 1));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({24'h0, pinsN}, {24'h0, 3'b101, ~CODE_START});
        rd(OFS_CTRL, 32'h0, RESP_OKAY);
        rd(OFS_STAT, 32'h0, RESP_OKAY);
        rd(OFS_CODE, {24'h0, CODE_START}, RESP_OKAY);
        rd(OFS_IRQS, 32'h0, RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h1C, 32'h0, RESP_SLVERR);
        $display("Test reset and register map done");
        for (i = 0; i < 3; i++) begin
            offset <= offs[i];
            delay <= (i == 0) ? 8'h00 : 8'($urandom_range(40, 1));
            s0 = starts;
            wr(OFS_CTRL, 32'h1, RESP_OKAY);
            repeat (2) @(negedge clk);
            chk({33'h0, pinsN.shortSw, pinsN.signalSw}, 35'h1);
            // Requests made mid-sequence must not add trials.
            wr(OFS_CTRL, 32'h2, RESP_OKAY);
            wr(OFS_CTRL, 32'h1, RESP_OKAY);
            wait_until(1'b0);
            c = CODE_START;
            for (p = PTR_START; p != 8'h0; p = p >> 1) begin
                c = (offs[i] > c) ? (c | p) : (c & ~p);
            end
            chk({27'h0, starts - s0}, 35'd8);
            chk({27'h0, ~pinsN.code}, {27'h0, c});
            rd(OFS_CODE, {24'h0, c}, RESP_OKAY);
            repeat (20) @(negedge clk);
            chk({26'h0, irq, ~pinsN.code}, {27'h0, c});
            $display("Test zeroing run %0d done", i);
        end
        sigVal <= 8'($urandom_range(255, 1));
        wr(OFS_IRQM, 32'h4, RESP_OKAY);
        rd(OFS_IRQM, 32'h4, RESP_OKAY);
        s0 = starts;
        wr(OFS_CTRL, 32'h2, RESP_OKAY);
        wait_until(1'b1);
        chk({27'h0, starts - s0}, 35'd1);
        rd(OFS_DATA, {24'h0, sigVal}, RESP_OKAY);
        rd(OFS_STAT, 32'h2, RESP_OKAY);
        rd(OFS_IRQS, 32'h7, RESP_OKAY);
        wr(OFS_IRQS, 32'h7, RESP_OKAY);
        rd(OFS_IRQS, 32'h0, RESP_OKAY);
        @(negedge clk);
        chk({34'h0, irq}, 35'h0);
        $display("Test conversion and interrupt done");
        print_verdict();
    end
endmodule
`default_nettype wire
